/* common/sltc_regs.vh */
`ifndef SLTC_REGS_VH
`define SLTC_REGS_VH
`define SLTC_ADDR_CFG       4'h0
`define SLTC_ADDR_DELAY     4'h1
`define SLTC_ADDR_DEPTH     4'h2
`define SLTC_ADDR_STATUS    4'h3
`define SLTC_ADDR_RXDATA    4'h4
`define SLTC_ADDR_COUNT     4'h5
`define SLTC_PHY_232        2'h0
`define SLTC_PHY_422        2'h1
`define SLTC_PHY_485        2'h2
`define SLTC_PHY_KEEP       2'h3
`define SLTC_DUP_HALF       2'h0
`define SLTC_DUP_FULL       2'h1
`define SLTC_DUP_P2P        2'h2
`define SLTC_DUP_KEEP       2'h3
`define SLTC_FLOW_HW        2'h0
`define SLTC_FLOW_SW        2'h1
`define SLTC_FLOW_NONE      2'h2
`define SLTC_FLOW_KEEP      2'h3
`define SLTC_CFG_PHY_LSB    0
`define SLTC_CFG_DUP_LSB    2
`define SLTC_CFG_FLOW_LSB   4
`define SLTC_DELAY_MAX      16'hfffe
`define SLTC_DELAY_KEEP     16'hffff
`define SLTC_DELAY_RST      16'h0000
`define SLTC_DEPTH_MIN      16'h0040
`define SLTC_DEPTH_MAX      16'h7fee
`define SLTC_DEPTH_RST      16'h0140
`define SLTC_DEPTH_KEEP     16'hffff
`define SLTC_MS_NS          1000000
`define SLTC_CLK_NS         50
`define SLTC_MS_CYCLES      (`SLTC_MS_NS / `SLTC_CLK_NS)
`endif

/* rtl/sltc_fifo.v */
`timescale 1ns/1ps
module sltc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!resetn || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sltc_fifo

/* rtl/sltc_top.v */
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sltc_regs.vh"
module sltc_top #(
  parameter PORT_ONE_FIXED = 1'b1,
  parameter DIFF_CAPABLE   = 1'b1,
  parameter MS_CYCLES      = `SLTC_MS_CYCLES,
  parameter FIFO_DEPTH     = 16,
  parameter FIFO_AW        = 4
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        port_is_one,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata,
  input  wire        tx_busy,
  input  wire        tx_start_req,
  output reg         tx_go,
  input  wire        cts,
  output reg         rts,
  output reg         rts_oe,
  output reg         txd_oe,
  output reg         rx_enable,
  output reg         tx_done,
  input  wire [7:0]  rx_char,
  input  wire        rx_char_valid,
  output reg         rx_overflow,
  output reg  [1:0]  phy_mode,
  output reg  [1:0]  flow_mode
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_SEND = 2'd2;
  localparam ST_HOLD = 2'd3;

  reg  [1:0]  state;
  reg  [1:0]  duplex;
  reg  [15:0] delay_ms;
  reg  [15:0] depth;
  reg  [15:0] ms_left;
  reg  [31:0] tick_cnt;
  reg  [15:0] level;
  reg         sticky_ovf;
  reg         phy_done;
  reg         pop_rd;
  wire [7:0]  fifo_dout;
  wire        fifo_valid;
  wire        fifo_in_ready;
  wire        fifo_push;
  wire        diff;
  wire        window;
  wire [1:0]  w_phy;
  wire [1:0]  w_dup;
  wire [1:0]  w_flow;
  wire        ms_tick;
  wire        accept;

  function phy_ok;
    input [1:0] sel;
    input       is_one;
    begin
      if (sel == `SLTC_PHY_232) begin
        phy_ok = 1'b1;
      end else if (sel == `SLTC_PHY_422 || sel == `SLTC_PHY_485) begin
        phy_ok = DIFF_CAPABLE && !(is_one && PORT_ONE_FIXED);
      end else begin
        phy_ok = 1'b0;
      end
    end
  endfunction

  assign w_phy  = wdata[`SLTC_CFG_PHY_LSB+1:`SLTC_CFG_PHY_LSB];
  assign w_dup  = wdata[`SLTC_CFG_DUP_LSB+1:`SLTC_CFG_DUP_LSB];
  assign w_flow = wdata[`SLTC_CFG_FLOW_LSB+1:`SLTC_CFG_FLOW_LSB];
  assign diff   = (phy_mode != `SLTC_PHY_232);
  assign window = (state != ST_IDLE);
  assign ms_tick = (tick_cnt == MS_CYCLES - 1);
  // Level counts stored chars; depth-1 leaves one slot as overflow guard
  assign accept    = (level < depth - 16'h0001);
  assign fifo_push = rx_char_valid && accept && fifo_in_ready;

  sltc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (1'b0),
    .in_data   (rx_char),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_dout),
    .out_valid (fifo_valid),
    .out_ready (pop_rd)
  );

  always @* begin
    pop_rd = rd_stb && (addr == `SLTC_ADDR_RXDATA) && fifo_valid;
  end

  // Configuration registers; a KEEP code leaves a field untouched
  always @(posedge clk) begin
    if (!resetn) begin
      phy_mode  <= `SLTC_PHY_232;
      duplex    <= `SLTC_DUP_FULL;
      flow_mode <= `SLTC_FLOW_HW;
      delay_ms  <= `SLTC_DELAY_RST;
      depth     <= `SLTC_DEPTH_RST;
      phy_done  <= 1'b0;
    end else begin
      // Strap may differ per variant, so it is sampled after release
      if (!phy_done) begin
        phy_done <= 1'b1;
        if (DIFF_CAPABLE && !port_is_one && !PORT_ONE_FIXED) begin
          phy_mode <= `SLTC_PHY_485;
        end
      end
      if (wr_stb && addr == `SLTC_ADDR_CFG) begin
        if (w_phy != `SLTC_PHY_KEEP && phy_ok(w_phy, port_is_one)) begin
          phy_mode <= w_phy;
        end
        if (w_dup != `SLTC_DUP_KEEP) begin
          duplex <= w_dup;
        end
        if (w_flow != `SLTC_FLOW_KEEP) begin
          flow_mode <= w_flow;
        end
      end else if (wr_stb && addr == `SLTC_ADDR_DELAY) begin
        if (wdata[15:0] <= `SLTC_DELAY_MAX) begin
          delay_ms <= wdata[15:0];
        end
      end else if (wr_stb && addr == `SLTC_ADDR_DEPTH) begin
        if (wdata[15:0] >= `SLTC_DEPTH_MIN && wdata[15:0] <= `SLTC_DEPTH_MAX) begin
          depth <= wdata[15:0];
        end
      end
    end
  end

  // Transmit window sequencer
  always @(posedge clk) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      ms_left  <= 16'h0000;
      tick_cnt <= 32'h0000_0000;
      tx_go    <= 1'b0;
      tx_done  <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tick_cnt <= (state == ST_HOLD && !ms_tick) ? tick_cnt + 32'h0000_0001 : 32'h0000_0000;
      case (state)
        ST_IDLE: begin
          tx_go <= 1'b0;
          if (tx_start_req) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (flow_mode != `SLTC_FLOW_HW || cts) begin
            tx_go <= 1'b1;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          tx_go <= 1'b1;
          if (!tx_busy && !tx_start_req) begin
            ms_left <= delay_ms;
            state   <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (tx_start_req || tx_busy) begin
            state <= ST_SEND;
          end else if (ms_left == 16'h0000) begin
            state   <= ST_IDLE;
            tx_go   <= 1'b0;
            tx_done <= 1'b1;
          end else if (ms_tick) begin
            ms_left <= ms_left - 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Line drivers and receiver gate, released in the same edge; in P2P duplex the drivers stay on with diff
  always @(posedge clk) begin
    if (!resetn) begin
      rts       <= 1'b0;
      rts_oe    <= 1'b0;
      txd_oe    <= 1'b0;
      rx_enable <= 1'b1;
    end else begin
      rts <= window && flow_mode == `SLTC_FLOW_HW && !(state == ST_HOLD && ms_left == 16'h0000
             && !tx_start_req && !tx_busy);
      if (duplex == `SLTC_DUP_P2P) begin
        rts_oe    <= diff;
        txd_oe    <= diff;
        rx_enable <= 1'b1;
      end else begin
        rts_oe    <= diff && window && !(state == ST_HOLD && ms_left == 16'h0000
                     && !tx_start_req && !tx_busy);
        txd_oe    <= diff && window && !(state == ST_HOLD && ms_left == 16'h0000
                     && !tx_start_req && !tx_busy);
        rx_enable <= (duplex == `SLTC_DUP_FULL) || !window
                     || (state == ST_HOLD && ms_left == 16'h0000
                     && !tx_start_req && !tx_busy);
      end
    end
  end

  // Receive buffer occupancy; FIFO is the near store, depth the policy
  always @(posedge clk) begin
    if (!resetn) begin
      level       <= 16'h0000;
      sticky_ovf  <= 1'b0;
      rx_overflow <= 1'b0;
    end else begin
      if (fifo_push && !pop_rd) begin
        level <= level + 16'h0001;
      end else if (pop_rd && !fifo_push) begin
        level <= level - 16'h0001;
      end
      rx_overflow <= rx_char_valid && !fifo_push;
      if (rx_char_valid && !fifo_push) begin
        sticky_ovf <= 1'b1;
      end else if (rd_stb && addr == `SLTC_ADDR_STATUS) begin
        sticky_ovf <= 1'b0;
      end
    end
  end

  // Read port, data one cycle after strobe
  always @(posedge clk) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      if (addr == `SLTC_ADDR_CFG) begin
        rdata <= {26'h000_0000, flow_mode, duplex, phy_mode};
      end else if (addr == `SLTC_ADDR_DELAY) begin
        rdata <= {16'h0000, delay_ms};
      end else if (addr == `SLTC_ADDR_DEPTH) begin
        rdata <= {16'h0000, depth};
      end else if (addr == `SLTC_ADDR_STATUS) begin
        rdata <= {27'h000_0000, sticky_ovf, rx_enable, txd_oe, state};
      end else if (addr == `SLTC_ADDR_RXDATA) begin
        rdata <= {23'h00_0000, fifo_valid, fifo_valid ? fifo_dout : 8'h00};
      end else if (addr == `SLTC_ADDR_COUNT) begin
        rdata <= {16'h0000, level};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule // sltc_top

/* bench/sltc_remote.sv */
`timescale 1ns/1ps
module sltc_remote (
  input  logic       clk,
  input  logic       rts,
  input  logic [3:0] lag,
  input  logic       send,
  input  logic [7:0] char_in,
  output logic       cts = 1'b0,
  output logic       rx_char_valid = 1'b0,
  output logic [7:0] rx_char = 8'h00
);
  logic [3:0] wait_cnt = 4'h0;
  // Slow answer when lag is large; cts falls one cycle after rts
  always @(posedge clk) begin
    wait_cnt <= !rts ? 4'h0 : (wait_cnt == lag ? wait_cnt : wait_cnt + 4'h1);
    cts <= rts && (wait_cnt == lag);
    rx_char_valid <= send;
    // Idle data toggles so a stale char is never mistaken for a new one
    rx_char <= send ? char_in : ~rx_char;
  end
endmodule // sltc_remote

/* bench/sltc_top_chk.sv */
`timescale 1ns/1ps
module sltc_top_chk (
  input logic        clk,
  input logic        resetn,
  input logic        rd_stb,
  input logic [31:0] rdata,
  input logic        tx_busy,
  input logic        tx_start_req,
  input logic        tx_go,
  input logic        cts,
  input logic        rts,
  input logic        rts_oe,
  input logic        txd_oe,
  input logic        rx_enable,
  input logic        tx_done,
  input logic        rx_char_valid,
  input logic        rx_overflow,
  input logic [1:0]  phy_mode,
  input logic [1:0]  flow_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  release_all_a: assert property (tx_done |-> !rts && !tx_go && rx_enable)
    else $error("release actions not together");
  done_pulse_a: assert property (tx_done |=> !tx_done)
    else $error("completion longer than one cycle");
  rs232_quiet_a: assert property (phy_mode == 2'h0 |-> !txd_oe && !rts_oe)
    else $error("driver enabled in single ended mode");
  phy_code_a: assert property (phy_mode != 2'h3)
    else $error("bad line mode code");
  cts_gate_a: assert property ($rose(tx_go) && flow_mode == 2'h0 |-> $past(cts))
    else $error("send began without clear to send");
  sw_no_rts_a: assert property (flow_mode != 2'h0 |-> !rts)
    else $error("request raised without hardware flow");
  busy_hold_a: assert property (tx_busy || tx_start_req |=> !tx_done)
    else $error("release while data pending");
  rx_gate_a: assert property (!rx_enable |-> tx_go || tx_start_req)
    else $error("receiver off outside window");
  ovf_cause_a: assert property (rx_overflow |-> $past(rx_char_valid))
    else $error("overflow without a char");
  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  cover property (tx_done);
  cover property (rx_overflow);
  cover property ($rose(txd_oe) && !rx_enable);
endmodule // sltc_top_chk

bind sltc_top sltc_top_chk u_chk (.clk(clk), .resetn(resetn), .rd_stb(rd_stb), .rdata(rdata),
  .tx_busy(tx_busy), .tx_start_req(tx_start_req), .tx_go(tx_go), .cts(cts), .rts(rts),
  .rts_oe(rts_oe), .txd_oe(txd_oe), .rx_enable(rx_enable), .tx_done(tx_done),
  .rx_char_valid(rx_char_valid), .rx_overflow(rx_overflow), .phy_mode(phy_mode),
  .flow_mode(flow_mode));

/* bench/sltc_top_tb.sv */
`timescale 1ns/1ps
module sltc_top_tb;
  logic        clk = 0, resetn = 0, port_is_one = 1, wr_stb = 0, rd_stb = 0, send = 0;
  logic        tx_busy = 0, tx_start_req = 0, tx_go, cts, rts, rts_oe, txd_oe;
  logic        rx_enable, tx_done, rx_char_valid, rx_overflow;
  logic [3:0]  addr = 0, lag = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [7:0]  char_in = 0, rx_char;
  logic [1:0]  phy_mode, flow_mode;
  logic [7:0]  q[$];
  int          err_total = 0, checks = 0, cyc = 0, ovf = 0, dl;
  sltc_top #(.MS_CYCLES(4), .FIFO_DEPTH(64), .FIFO_AW(6)) u_sltc_top (.clk(clk),
    .resetn(resetn), .port_is_one(port_is_one), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .tx_busy(tx_busy), .tx_start_req(tx_start_req),
    .tx_go(tx_go), .cts(cts), .rts(rts), .rts_oe(rts_oe), .txd_oe(txd_oe),
    .rx_enable(rx_enable), .tx_done(tx_done), .rx_char(rx_char),
    .rx_char_valid(rx_char_valid), .rx_overflow(rx_overflow), .phy_mode(phy_mode),
    .flow_mode(flow_mode));
  sltc_remote u_sltc_remote (.clk(clk), .rts(rts), .lag(lag), .send(send),
    .char_in(char_in), .cts(cts), .rx_char_valid(rx_char_valid), .rx_char(rx_char));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rx_overflow === 1'b1) ovf++;
    if (cyc == 8000) begin
      err_total++;
      wrap_up;
    end
  end
  function logic [31:0] cfg(input logic [1:0] p, d, f);
    cfg = {26'h0, f, d, p};
  endfunction
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task rst;
    @(posedge clk) resetn <= 0;
    repeat (10) @(posedge clk);
    resetn <= 1;
    repeat (2) @(negedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge clk) wr_stb <= 0;
    repeat (2) @(negedge clk);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge clk) rd_stb <= 0;
    @(negedge clk) d = rdata;
  endtask
  // Busy for five cycles; release measured from the busy fall
  task xmit(input int dl, input logic [1:0] dp, fl);
    int n;
    chk(txd_oe, 0);
    @(posedge clk) tx_start_req <= 1;
    n = 0;
    while (tx_go !== 1'b1 && n < 99) begin @(negedge clk); n++; end
    repeat (2) @(negedge clk);
    chk({txd_oe, rts_oe, rts, rx_enable}, {2'b11, fl == 0, dp != 0});
    @(posedge clk) {tx_busy, tx_start_req} <= 2'b10;
    repeat (5) @(posedge clk);
    tx_busy <= 0;
    n = 0;
    while (tx_done !== 1'b1 && n < 99) begin @(negedge clk); n++; end
    chk(n + 4 >= 4 * dl && n <= 4 * dl + 8, 1);
    chk({txd_oe, rts_oe, rts, rx_enable}, 4'b0001);
  endtask
  initial begin
    void'($urandom(29));
    rst;
    chk({phy_mode, flow_mode, rts, txd_oe, rx_enable}, 7'b0000001);
    rd(1, v); chk(v, 32'h0000_0000);
    rd(2, v); chk(v, 32'h0000_0140);
    rd(4'hf, v); chk(v, 32'h0000_0000);
    wr(0, cfg(2, 3, 3)); chk(phy_mode, 0);
    port_is_one <= 0;
    rst;
    wr(0, cfg(1, 3, 3)); chk(phy_mode, 1);
    wr(0, cfg(3, 3, 3)); chk(phy_mode, 1);
    wr(1, 32'h0000_fffe); rd(1, v); chk(v, 32'h0000_fffe);
    wr(1, 32'h0000_ffff); rd(1, v); chk(v, 32'h0000_fffe);
    wr(0, cfg(2, 2, 3)); chk({txd_oe, rts_oe, rx_enable}, 3'b111);
    for (int i = 0; i < 3; i++) begin
      dl = $urandom_range(3);
      lag <= 4'($urandom_range(6));
      wr(1, dl);
      wr(0, cfg(2, i == 0 ? 2'h0 : 2'h1, 2'(i)));
      xmit(dl, i == 0 ? 2'h0 : 2'h1, 2'(i));
    end
    wr(2, 32'h0000_0040); wr(2, 32'h0000_003f); rd(2, v); chk(v, 32'h0000_0040);
    repeat (64) begin
      @(posedge clk) {send, char_in} <= {1'b1, 8'($urandom)};
      @(negedge clk) q.push_back(char_in);
    end
    @(posedge clk) send <= 0;
    void'(q.pop_back());
    repeat (3) @(negedge clk);
    chk(ovf, 1);
    rd(5, v); chk(v, 32'd63);
    rd(3, v); chk(v[4], 1);
    rd(3, v); chk(v[4], 0);
    while (q.size() > 0) begin rd(4, v); chk(v, {23'h0, 1'b1, q.pop_front()}); end
    rd(4, v); chk(v[8], 0);
    wrap_up;
  end
  task wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule // sltc_top_tb
